/* verilog/itfm_top.sv */
// Input terminal function mapper with classic Wishbone register slave
//
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module itfm_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [4:0]  terminal_i,
  output logic             servo_on_o,
  output logic             fault_reset_o,
  output logic             prop_control_o,
  output logic             droop_clear_o,
  output logic             speed_select_bit1_o,
  output logic             speed_select_bit2_o,
  output logic             speed_select_bit3_o,
  output logic             forward_start_o,
  output logic             reverse_start_o,
  output logic             gear_numerator_select1_o,
  output logic             gear_numerator_select2_o,
  output logic             internal_torque_limit_select_o,
  output logic             gain_switch_select_o,
  output logic             forward_travel_limit_o,
  output logic             reverse_travel_limit_o,
  output logic             control_mode_change_o,
  output logic             speed_mode_o
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  mode;
    logic [15:0] first_sel;
    logic [15:0] t4_sel;
    logic [15:0] t3_sel;
    logic [15:0] t5_sel;
    logic [15:0] t6_sel;
    logic [15:0] t7_sel;
    logic [15:0] placement;
    logic [15:0] func;
    logic        fwd;
    logic        rev;
    logic        mchg;
    logic        speed;
    logic        droop;
    logic        ack;
    logic [31:0] dat;
  } itfm_state_type;

  itfm_state_type st_reg;
  itfm_state_type st_next;

  // ----------------------------------------------------------------------
  // Mapping logic
  // ----------------------------------------------------------------------
  logic [15:0] sel_arr  [itfm_pkg::NUM_TERMS];
  logic [15:0] fn_arr   [itfm_pkg::NUM_TERMS];
  logic [3:0]  term_code[itfm_pkg::NUM_TERMS];
  logic [4:0]  term_en;
  logic [4:0]  mchg_pins;
  logic [4:0]  fwd_pins;
  logic [4:0]  rev_pins;
  logic        change_mode;
  logic        mchg_level;
  logic        speed_act;
  logic        fwd_keep6;
  logic        rev_keep7;
  logic        fwd_eff;
  logic        rev_eff;
  logic [15:0] func_comb;
  logic        droop_level;
  logic        bus_req;

  assign sel_arr[itfm_pkg::TERM_3] = st_reg.t3_sel;
  assign sel_arr[itfm_pkg::TERM_4] = st_reg.t4_sel;
  assign sel_arr[itfm_pkg::TERM_5] = st_reg.t5_sel;
  assign sel_arr[itfm_pkg::TERM_6] = st_reg.t6_sel;
  assign sel_arr[itfm_pkg::TERM_7] = st_reg.t7_sel;

  // The mode-change input only exists in the combined mode
  assign change_mode = (st_reg.mode == itfm_pkg::MODE_CHANGE);
  assign mchg_pins   = itfm_pkg::pin_onehot(st_reg.first_sel[itfm_pkg::MCHG_PIN_LSB +: 4]);
  assign mchg_level  = change_mode && |(mchg_pins & terminal_i);
  assign speed_act   = (st_reg.mode == itfm_pkg::MODE_SPEED) || mchg_level;

  assign fwd_pins = itfm_pkg::pin_onehot(st_reg.placement[itfm_pkg::FWD_PIN_LSB +: 4]);
  assign rev_pins = itfm_pkg::pin_onehot(st_reg.placement[itfm_pkg::REV_PIN_LSB +: 4]);

  genvar k;
  generate
    for (k = 0; k < itfm_pkg::NUM_TERMS; k++) begin : g_code
      assign term_code[k] = itfm_pkg::mode_digit(sel_arr[k], speed_act);
    end
  endgenerate

  // A live function on terminal 6 takes the pin back from the forward limit, one on terminal 7 from the reverse limit
  assign fwd_keep6 = fwd_pins[itfm_pkg::TERM_6] &&
                     itfm_pkg::fn_valid(term_code[itfm_pkg::TERM_6], speed_act);
  assign rev_keep7 = rev_pins[itfm_pkg::TERM_7] &&
                     itfm_pkg::fn_valid(term_code[itfm_pkg::TERM_7], speed_act);
  assign fwd_eff   = (|fwd_pins) && !fwd_keep6;
  assign rev_eff   = (|rev_pins) && !rev_keep7 && (rev_pins != fwd_pins);

  always_comb begin
    term_en = ~(({5{fwd_eff}} & fwd_pins) | ({5{rev_eff}} & rev_pins));
    if (change_mode && mchg_pins[itfm_pkg::TERM_4]) begin
      term_en[itfm_pkg::TERM_4] = 1'b0;
    end
    if (fwd_pins[itfm_pkg::TERM_4] || rev_pins[itfm_pkg::TERM_4]) begin
      term_en[itfm_pkg::TERM_4] = 1'b0;
    end
  end

  generate
    for (k = 0; k < itfm_pkg::NUM_TERMS; k++) begin : g_term
      itfm_term_decode u_decode (
        .sel_i    (sel_arr[k]),
        .speed_i  (speed_act),
        .enable_i (term_en[k]),
        .level_i  (terminal_i[k]),
        .fn_vec_o (fn_arr[k])
      );
    end
  endgenerate

  // Several terminals may pick one function; any of them asserts it
  always_comb begin
    func_comb = 16'h0000;
    for (int i = 0; i < itfm_pkg::NUM_TERMS; i++) begin
      func_comb = func_comb | fn_arr[i];
    end
  end

  assign droop_level = func_comb[itfm_pkg::FN_DROOP_CLEAR];
  assign bus_req     = cyc_i && stb_i;

  // ----------------------------------------------------------------------
  // Register access helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                       input logic [3:0] be);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = d[7:0];
    end
    if (be[1]) begin
      v[15:8] = d[15:8];
    end
    return v;
  endfunction

  function automatic logic [31:0] ext16(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    st_next.func  = func_comb;
    st_next.fwd   = fwd_eff && |(fwd_pins & terminal_i);
    st_next.rev   = rev_eff && |(rev_pins & terminal_i);
    st_next.mchg  = mchg_level;
    st_next.speed = speed_act;
    // Edge mode compares with the registered level of the previous cycle
    if (st_reg.first_sel[itfm_pkg::DROOP_MODE_BIT]) begin
      st_next.droop = droop_level;
    end else begin
      st_next.droop = droop_level && !st_reg.func[itfm_pkg::FN_DROOP_CLEAR];
    end

    // Ack one cycle after the request; the write lands on the acking edge
    st_next.ack = bus_req && !st_reg.ack;
    if (bus_req && !st_reg.ack) begin
      case (adr_i)
        itfm_pkg::ADDR_CONTROL_MODE:    st_next.dat = {30'h0, st_reg.mode};
        itfm_pkg::ADDR_FIRST_SELECTION: st_next.dat = ext16(st_reg.first_sel);
        itfm_pkg::ADDR_TERMINAL4_SEL:   st_next.dat = ext16(st_reg.t4_sel);
        itfm_pkg::ADDR_TERMINAL3_SEL:   st_next.dat = ext16(st_reg.t3_sel);
        itfm_pkg::ADDR_TERMINAL5_SEL:   st_next.dat = ext16(st_reg.t5_sel);
        itfm_pkg::ADDR_TERMINAL6_SEL:   st_next.dat = ext16(st_reg.t6_sel);
        itfm_pkg::ADDR_TERMINAL7_SEL:   st_next.dat = ext16(st_reg.t7_sel);
        itfm_pkg::ADDR_LIMIT_PLACEMENT: st_next.dat = ext16(st_reg.placement);
        itfm_pkg::ADDR_TERMINAL_STATUS: st_next.dat = {27'h0, terminal_i};
        itfm_pkg::ADDR_FUNCTION_STATUS: begin
          st_next.dat = ext16(st_reg.func);
          st_next.dat[itfm_pkg::STAT_FWD_BIT]   = st_reg.fwd;
          st_next.dat[itfm_pkg::STAT_REV_BIT]   = st_reg.rev;
          st_next.dat[itfm_pkg::STAT_MCHG_BIT]  = st_reg.mchg;
          st_next.dat[itfm_pkg::STAT_SPEED_BIT] = st_reg.speed;
        end
        default: st_next.dat = 32'h00000000;
      endcase
    end
    if (bus_req && st_reg.ack && we_i) begin
      case (adr_i)
        itfm_pkg::ADDR_CONTROL_MODE: begin
          if (sel_i[0]) begin
            st_next.mode = dat_i[1:0];
          end
        end
        itfm_pkg::ADDR_FIRST_SELECTION: st_next.first_sel = wr16(st_reg.first_sel, dat_i, sel_i);
        itfm_pkg::ADDR_TERMINAL4_SEL:   st_next.t4_sel    = wr16(st_reg.t4_sel, dat_i, sel_i);
        itfm_pkg::ADDR_TERMINAL3_SEL:   st_next.t3_sel    = wr16(st_reg.t3_sel, dat_i, sel_i);
        itfm_pkg::ADDR_TERMINAL5_SEL:   st_next.t5_sel    = wr16(st_reg.t5_sel, dat_i, sel_i);
        itfm_pkg::ADDR_TERMINAL6_SEL:   st_next.t6_sel    = wr16(st_reg.t6_sel, dat_i, sel_i);
        itfm_pkg::ADDR_TERMINAL7_SEL:   st_next.t7_sel    = wr16(st_reg.t7_sel, dat_i, sel_i);
        itfm_pkg::ADDR_LIMIT_PLACEMENT: st_next.placement = wr16(st_reg.placement, dat_i, sel_i);
        default: st_next.mode = st_reg.mode;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg           <= '0;
      st_reg.mode      <= itfm_pkg::RST_CONTROL_MODE;
      st_reg.first_sel <= itfm_pkg::RST_FIRST_SELECTION;
      st_reg.t4_sel    <= itfm_pkg::RST_TERMINAL4_SEL;
      st_reg.t3_sel    <= itfm_pkg::RST_TERMINAL3_SEL;
      st_reg.t5_sel    <= itfm_pkg::RST_TERMINAL5_SEL;
      st_reg.t6_sel    <= itfm_pkg::RST_TERMINAL6_SEL;
      st_reg.t7_sel    <= itfm_pkg::RST_TERMINAL7_SEL;
      st_reg.placement <= itfm_pkg::RST_LIMIT_PLACEMENT;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign dat_o                          = st_reg.dat;
  assign ack_o                          = st_reg.ack;
  assign servo_on_o                     = st_reg.func[itfm_pkg::FN_SERVO_ON];
  assign fault_reset_o                  = st_reg.func[itfm_pkg::FN_FAULT_RESET];
  assign prop_control_o                 = st_reg.func[itfm_pkg::FN_PROP_CONTROL];
  assign droop_clear_o                  = st_reg.droop;
  assign speed_select_bit1_o            = st_reg.func[itfm_pkg::FN_SPEED_BIT1];
  assign speed_select_bit2_o            = st_reg.func[itfm_pkg::FN_SPEED_BIT2];
  assign speed_select_bit3_o            = st_reg.func[itfm_pkg::FN_SPEED_BIT3];
  assign forward_start_o                = st_reg.func[itfm_pkg::FN_FWD_START];
  assign reverse_start_o                = st_reg.func[itfm_pkg::FN_REV_START];
  assign gear_numerator_select1_o       = st_reg.func[itfm_pkg::FN_GEAR_SEL1];
  assign gear_numerator_select2_o       = st_reg.func[itfm_pkg::FN_GEAR_SEL2];
  assign internal_torque_limit_select_o = st_reg.func[itfm_pkg::FN_TORQUE_LIMIT];
  assign gain_switch_select_o           = st_reg.func[itfm_pkg::FN_GAIN_SWITCH];
  assign forward_travel_limit_o         = st_reg.fwd;
  assign reverse_travel_limit_o         = st_reg.rev;
  assign control_mode_change_o          = st_reg.mchg;
  assign speed_mode_o                   = st_reg.speed;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_route(logic en, logic lvl, logic [3:0] code);
    (en && lvl && itfm_pkg::fn_valid(code, speed_act)) |=> st_reg.func[$past(code)];
  endproperty

  sequence s_droop_rise;
    !st_reg.first_sel[itfm_pkg::DROOP_MODE_BIT] && $rose(droop_level);
  endsequence

  sequence s_droop_held;
    !st_reg.first_sel[itfm_pkg::DROOP_MODE_BIT] && droop_level;
  endsequence

  a_route_term3: assert property (
    p_route(term_en[itfm_pkg::TERM_3], terminal_i[itfm_pkg::TERM_3],
            term_code[itfm_pkg::TERM_3]))
    else $error("terminal 3 function not routed");

  a_route_term5: assert property (
    p_route(term_en[itfm_pkg::TERM_5], terminal_i[itfm_pkg::TERM_5],
            term_code[itfm_pkg::TERM_5]))
    else $error("terminal 5 function not routed");

  a_route_term6: assert property (
    p_route(term_en[itfm_pkg::TERM_6], terminal_i[itfm_pkg::TERM_6],
            term_code[itfm_pkg::TERM_6]))
    else $error("terminal 6 function not routed");

  a_route_term7: assert property (
    p_route(term_en[itfm_pkg::TERM_7], terminal_i[itfm_pkg::TERM_7],
            term_code[itfm_pkg::TERM_7]))
    else $error("terminal 7 function not routed");

  a_fwd_limit_pin: assert property (
    (fwd_eff && |(fwd_pins & terminal_i)) |=> forward_travel_limit_o)
    else $error("forward limit not taken from its pin");

  a_limit_precedence: assert property (
    (fwd_eff && terminal_i == fwd_pins) |=> (st_reg.func == 16'h0000))
    else $error("selection active on forward limit pin");

  a_term6_override: assert property (
    (fwd_pins[itfm_pkg::TERM_6] &&
     itfm_pkg::fn_valid(term_code[itfm_pkg::TERM_6], speed_act)) |=> !forward_travel_limit_o)
    else $error("forward limit not yielding to terminal 6");

  a_term7_override: assert property (
    (rev_pins[itfm_pkg::TERM_7] &&
     itfm_pkg::fn_valid(term_code[itfm_pkg::TERM_7], speed_act)) |=> !reverse_travel_limit_o)
    else $error("reverse limit not yielding to terminal 7");

  a_shared_limit: assert property (
    ((|fwd_pins) && fwd_pins == rev_pins && !fwd_keep6 && |(fwd_pins & terminal_i))
    |=> forward_travel_limit_o && !reverse_travel_limit_o)
    else $error("shared limit pin not forward only");

  a_mchg_term4: assert property (
    (change_mode && mchg_pins[itfm_pkg::TERM_4] && terminal_i == 5'h02)
    |=> (st_reg.func == 16'h0000))
    else $error("terminal 4 selection used under mode change");

  a_limit_term4: assert property (
    ((fwd_pins[itfm_pkg::TERM_4] || rev_pins[itfm_pkg::TERM_4]) && terminal_i == 5'h02)
    |=> (st_reg.func == 16'h0000))
    else $error("terminal 4 selection used under limit");

  a_mchg_mode_only: assert property (
    !change_mode |=> !control_mode_change_o &&
                     (speed_mode_o == ($past(st_reg.mode) == itfm_pkg::MODE_SPEED)))
    else $error("mode change active outside combined mode");

  a_droop_edge: assert property (
    s_droop_rise ##1 s_droop_held |-> droop_clear_o ##1 !droop_clear_o)
    else $error("edge droop clear not a single pulse");

  a_idle_inactive: assert property (
    (terminal_i == 5'h00) |=> (st_reg.func == 16'h0000) && !forward_travel_limit_o &&
                              !reverse_travel_limit_o && !droop_clear_o)
    else $error("function active with all terminals off");

  a_bus_ack: assert property (
    (bus_req && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("bus ack not a single cycle");

endmodule

/* verilog/itfm_pkg.sv */
// Constants, codes and helper functions of the input terminal function mapper
package itfm_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL_MODE    = 8'h00;
  localparam logic [7:0] ADDR_FIRST_SELECTION = 8'h04;
  localparam logic [7:0] ADDR_TERMINAL4_SEL   = 8'h08;
  localparam logic [7:0] ADDR_TERMINAL3_SEL   = 8'h0c;
  localparam logic [7:0] ADDR_TERMINAL5_SEL   = 8'h10;
  localparam logic [7:0] ADDR_TERMINAL6_SEL   = 8'h14;
  localparam logic [7:0] ADDR_TERMINAL7_SEL   = 8'h18;
  localparam logic [7:0] ADDR_LIMIT_PLACEMENT = 8'h1c;
  localparam logic [7:0] ADDR_TERMINAL_STATUS = 8'h20;
  localparam logic [7:0] ADDR_FUNCTION_STATUS = 8'h24;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0]  RST_CONTROL_MODE    = 2'h0;
  localparam logic [15:0] RST_FIRST_SELECTION = 16'h0002;
  localparam logic [15:0] RST_TERMINAL4_SEL   = 16'h0111;
  localparam logic [15:0] RST_TERMINAL3_SEL   = 16'h0882;
  localparam logic [15:0] RST_TERMINAL5_SEL   = 16'h0995;
  localparam logic [15:0] RST_TERMINAL6_SEL   = 16'h0000;
  localparam logic [15:0] RST_TERMINAL7_SEL   = 16'h0000;
  localparam logic [15:0] RST_LIMIT_PLACEMENT = 16'h0403;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int POS_DIGIT_LSB   = 0;
  localparam int SPEED_DIGIT_LSB = 4;
  localparam int MCHG_PIN_LSB    = 0;
  localparam int DROOP_MODE_BIT  = 4;
  localparam int FWD_PIN_LSB     = 0;
  localparam int REV_PIN_LSB     = 8;
  localparam int STAT_FWD_BIT    = 16;
  localparam int STAT_REV_BIT    = 17;
  localparam int STAT_MCHG_BIT   = 18;
  localparam int STAT_SPEED_BIT  = 19;

  // ----------------------------------------------------------------------
  // Terminals: index into the terminal vector, and placement pin codes
  // ----------------------------------------------------------------------
  localparam int NUM_TERMS = 5;
  localparam int TERM_3    = 0;
  localparam int TERM_4    = 1;
  localparam int TERM_5    = 2;
  localparam int TERM_6    = 3;
  localparam int TERM_7    = 4;

  localparam logic [3:0] PIN_CODE_T4 = 4'h0;
  localparam logic [3:0] PIN_CODE_T3 = 4'h1;
  localparam logic [3:0] PIN_CODE_T5 = 4'h2;
  localparam logic [3:0] PIN_CODE_T6 = 4'h3;
  localparam logic [3:0] PIN_CODE_T7 = 4'h4;

  // ----------------------------------------------------------------------
  // Function codes of a selection digit
  // ----------------------------------------------------------------------
  localparam logic [3:0] FN_NONE         = 4'h0;
  localparam logic [3:0] FN_SERVO_ON     = 4'h1;
  localparam logic [3:0] FN_FAULT_RESET  = 4'h2;
  localparam logic [3:0] FN_PROP_CONTROL = 4'h3;
  localparam logic [3:0] FN_DROOP_CLEAR  = 4'h5;
  localparam logic [3:0] FN_SPEED_BIT1   = 4'h6;
  localparam logic [3:0] FN_SPEED_BIT2   = 4'h7;
  localparam logic [3:0] FN_FWD_START    = 4'h8;
  localparam logic [3:0] FN_REV_START    = 4'h9;
  localparam logic [3:0] FN_SPEED_BIT3   = 4'ha;
  localparam logic [3:0] FN_GEAR_SEL1    = 4'hb;
  localparam logic [3:0] FN_GEAR_SEL2    = 4'hc;
  localparam logic [3:0] FN_TORQUE_LIMIT = 4'hd;
  localparam logic [3:0] FN_GAIN_SWITCH  = 4'he;

  // Codes that name a function in each control mode
  localparam logic [15:0] POS_VALID_MASK   = 16'h782e;
  localparam logic [15:0] SPEED_VALID_MASK = 16'h67ee;

  typedef enum logic [1:0] {MODE_POSITION, MODE_SPEED, MODE_CHANGE} itfm_mode_type;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [3:0] mode_digit(input logic [15:0] sel, input logic speed);
    return speed ? sel[SPEED_DIGIT_LSB +: 4] : sel[POS_DIGIT_LSB +: 4];
  endfunction

  function automatic logic fn_valid(input logic [3:0] code, input logic speed);
    return speed ? SPEED_VALID_MASK[code] : POS_VALID_MASK[code];
  endfunction

  // Unknown pin codes place the signal nowhere
  function automatic logic [4:0] pin_onehot(input logic [3:0] code);
    logic [4:0] v;
    v = 5'h00;
    case (code)
      PIN_CODE_T3: v[TERM_3] = 1'b1;
      PIN_CODE_T4: v[TERM_4] = 1'b1;
      PIN_CODE_T5: v[TERM_5] = 1'b1;
      PIN_CODE_T6: v[TERM_6] = 1'b1;
      PIN_CODE_T7: v[TERM_7] = 1'b1;
      default:     v = 5'h00;
    endcase
    return v;
  endfunction

endpackage

/* verilog/itfm_term_decode.sv */
// Per-terminal decode of a selection setting into a one-hot function vector
`timescale 1ns/1ps
module itfm_term_decode (
  input  wire logic [15:0] sel_i,
  input  wire logic        speed_i,
  input  wire logic        enable_i,
  input  wire logic        level_i,
  output logic      [15:0] fn_vec_o
);

  logic [3:0] code;

  assign code = itfm_pkg::mode_digit(sel_i, speed_i);

  // Codes blank in the active mode drive nothing
  always_comb begin
    fn_vec_o = 16'h0000;
    if (enable_i && level_i && itfm_pkg::fn_valid(code, speed_i)) begin
      fn_vec_o[code] = 1'b1;
    end
  end

endmodule

/* dv/itfm_partner.sv */
// Model of the controller and limit switches that drive the input terminals
`timescale 1ns/1ps
module itfm_partner (
  input  wire logic       clk_i,
  input  wire logic [4:0] want_i,
  output logic      [4:0] terminal_o
);
  // Switches settle only at clock edges, so the mapper never sees a mid-cycle glitch
  initial terminal_o = 5'h00;
  always @(posedge clk_i) begin
    terminal_o <= want_i;
  end
endmodule

/* dv/itfm_top_tb_top.sv */
// Self-checking bench of the input terminal function mapper
`timescale 1ns/1ps
module itfm_top_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [4:0]  want = 5'h00, term;
  logic        ack_o;
  logic [15:0] ex;
  logic [5:0]  outs, rexp [5];
  logic [4:0]  rin [5];
  int          errors = 0, cmp_count = 0, k;
  wire logic [5:0] ov;
  wire logic [15:0] fv;
  always #50 clk_i = ~clk_i;
  itfm_partner u_far (.clk_i(clk_i), .want_i(want), .terminal_o(term));
  itfm_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .terminal_i(term), .servo_on_o(ov[5]), .fault_reset_o(ov[4]), .prop_control_o(fv[3]),
    .droop_clear_o(ov[3]), .speed_select_bit1_o(fv[6]), .speed_select_bit2_o(fv[7]),
    .speed_select_bit3_o(fv[10]), .forward_start_o(fv[8]), .reverse_start_o(fv[9]),
    .gear_numerator_select1_o(fv[11]), .gear_numerator_select2_o(fv[12]),
    .internal_torque_limit_select_o(fv[13]), .gain_switch_select_o(fv[14]),
    .forward_travel_limit_o(ov[2]), .reverse_travel_limit_o(ov[1]),
    .control_mode_change_o(ov[0]), .speed_mode_o(fv[15]));
  // Function pins gathered by code; bit 15 carries the speed mode flag
  assign fv[2:0] = {ov[4], ov[5], 1'b0};
  assign fv[5:4] = 2'h0;
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ack and read data are sampled at the edge itself, before the slave updates them
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {16'h0000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) errors++;
    q = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Partner edge, then mapper edge: four edges leave the outputs well settled
  task automatic drive(input logic [4:0] t);
    want <= t;
    repeat (4) @(posedge clk_i);
    outs = ov;
  endtask
  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    rin = '{5'h01, 5'h02, 5'h08, 5'h10, 5'h1f};
    rexp = '{6'h10, 6'h20, 6'h04, 6'h02, 6'h36};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, itfm_pkg::ADDR_TERMINAL3_SEL, 16'h0); chk("t3_sel", 16'h0882, q[15:0]);
    wb(1'b0, itfm_pkg::ADDR_TERMINAL5_SEL, 16'h0); chk("t5_sel", 16'h0995, q[15:0]);
    wb(1'b0, itfm_pkg::ADDR_TERMINAL6_SEL, 16'h0); chk("t6_sel", 16'h0000, q[15:0]);
    wb(1'b0, itfm_pkg::ADDR_TERMINAL7_SEL, 16'h0); chk("t7_sel", 16'h0000, q[15:0]);
    wb(1'b0, itfm_pkg::ADDR_LIMIT_PLACEMENT, 16'h0); chk("place", 16'h0403, q[15:0]);
    wb(1'b1, 8'h28, 16'hffff);
    wb(1'b0, 8'h28, 16'h0); chk("unmapped", 16'h0000, q[15:0]);
    for (k = 0; k < 5; k++) begin
      drive(rin[k]); chk("row", {10'h0, rexp[k]}, {10'h0, outs});
    end
    wb(1'b1, itfm_pkg::ADDR_TERMINAL6_SEL, 16'h0001);
    drive(5'h08); chk("t6_wins", 16'h0020, {10'h0, outs});
    wb(1'b1, itfm_pkg::ADDR_TERMINAL6_SEL, 16'h0000);
    wb(1'b1, itfm_pkg::ADDR_LIMIT_PLACEMENT, 16'h0303);
    drive(5'h18); chk("shared_pin", 16'h0004, {10'h0, outs});
    wb(1'b1, itfm_pkg::ADDR_LIMIT_PLACEMENT, 16'h0400);
    drive(5'h02); chk("limit_t4", 16'h0004, {10'h0, outs});
    wb(1'b1, itfm_pkg::ADDR_LIMIT_PLACEMENT, 16'h0403);
    wb(1'b1, itfm_pkg::ADDR_FIRST_SELECTION, 16'h0000);
    wb(1'b1, itfm_pkg::ADDR_CONTROL_MODE, 16'h0002);
    drive(5'h02); chk("lop_t4", 16'h0001, {10'h0, outs});
    drive(5'h03); chk("speed_t3", 16'h0001, {15'h0, fv[8]});
    wb(1'b1, itfm_pkg::ADDR_CONTROL_MODE, 16'h0000);
    wb(1'b1, itfm_pkg::ADDR_FIRST_SELECTION, 16'h0002);
    drive(5'h00);
    want <= 5'h04;
    k = 0;
    repeat (6) begin
      @(posedge clk_i);
      k += (ov[3] === 1'b1);
    end
    chk("droop_edge", 16'h0001, k[15:0]);
    wb(1'b1, itfm_pkg::ADDR_FIRST_SELECTION, 16'h0012);
    drive(5'h04); chk("droop_level", 16'h0008, {10'h0, outs});
    // Every code in both modes on terminal 3; droop clear is checked on its own pin above
    for (k = 0; k < 32; k++) begin
      wb(1'b1, itfm_pkg::ADDR_CONTROL_MODE, {15'h0, k[4]});
      wb(1'b1, itfm_pkg::ADDR_TERMINAL3_SEL, {8'h00, k[3:0], k[3:0]});
      drive(5'h01);
      ex = (k[4] ? 16'h67ce : 16'h780e) & (16'h0001 << k[3:0]);
      chk("fn_code", {k[4], ex[14:0]}, fv);
    end
    wb(1'b0, itfm_pkg::ADDR_TERMINAL_STATUS, 16'h0); chk("term_stat", 16'h0001, q[15:0]);
    wb(1'b0, itfm_pkg::ADDR_FUNCTION_STATUS, 16'h0); chk("func_stat", 16'h0008, q[31:16]);
    // Reset in mid-run: outputs drop at the next clock edge and settings return to defaults
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("rst_outs", 16'h0000, fv | {10'h0, ov});
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, itfm_pkg::ADDR_TERMINAL3_SEL, 16'h0); chk("rst_t3", 16'h0882, q[15:0]);
    wb(1'b0, itfm_pkg::ADDR_CONTROL_MODE, 16'h0); chk("rst_mode", 16'h0000, q[15:0]);
    chk("rst_map", 16'h0010, {10'h0, ov});
    give_verdict();
  end
  initial begin
    #(3000 * 100);
    errors++;
    give_verdict();
  end
endmodule
